//--- hw/clk_cfg_defs.svh
// constants for the clock output configuration select block
`ifndef CLK_CFG_DEFS_SVH
`define CLK_CFG_DEFS_SVH
`define CFG_COUNT 4
`define OUT_COUNT 3
`define DRIVE_WIDTH 2
`define SS_DEV_WIDTH 5
`define SS_RATE_WIDTH 4
`define OUT_EN_POS 0
`define OUT_INV_POS 1
`define OUT_BYP_POS 2
`define OUT_DRV_POS 3
`define OUT_FIELD_WIDTH 5
`define CFG_DIFF_POS 15
`define CFG_SS_ON_POS 16
`define CFG_SS_DEV_POS 17
`define CFG_SS_RATE_POS 22
`define CFG_WIDTH 26
`define CFG_RESET 26'h0000000
`endif

//--- hw/clk_cfg_pkg.sv
// types for the clock output configuration select block
`include "clk_cfg_defs.svh"
package clk_cfg_pkg;
	typedef logic [`CFG_WIDTH-1:0] cfg_word_type;
	typedef logic [1:0] cfg_sel_type;
	typedef enum logic [1:0] {
		st_down = 2'b00,
		st_blank = 2'b01,
		st_run = 2'b10
	} run_state_type;
endpackage

//--- hw/out_gate_if.sv
// signals between the selector and the output gate
`timescale 1ns/1ps
interface out_gate_if;
	logic run;
	logic [2:0] gate_en;
	logic [2:0] hiz_idle;
	logic [2:0] clk_src;
	logic [2:0] clk_out;
	logic [2:0] clk_oe_n;
	modport ctrl (output run, output gate_en, output hiz_idle, output clk_src, input clk_out, input clk_oe_n);
	modport gate (input run, input gate_en, input hiz_idle, input clk_src, output clk_out, output clk_oe_n);
endinterface

//--- hw/out_gate.sv
// per-output buffer gate with programmable idle level
`timescale 1ns/1ps
module out_gate (
	input wire sys_clk_in,
	input wire resetn_in,
	out_gate_if.gate g
);
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_out
			always_ff @(posedge sys_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					g.clk_out[i] <= 1'b0;
					g.clk_oe_n[i] <= 1'b0;
				end else if (!g.run) begin
					g.clk_out[i] <= 1'b0; // RL9
					g.clk_oe_n[i] <= 1'b0;
				end else if (g.gate_en[i]) begin
					g.clk_out[i] <= g.clk_src[i];
					g.clk_oe_n[i] <= 1'b0;
				end else begin
					g.clk_out[i] <= 1'b0; // RL8
					g.clk_oe_n[i] <= g.hiz_idle[i];
				end
			end
		end
	endgenerate
endmodule

//--- hw/clock_output_config_select.sv
// configuration select and output gating of a programmable clock generator
// How it works
// RL1 - two select pins pick the live configuration
// RL2 - four configuration slots held in storage
// RL3 - output runs when config bit and pin set
// RL4 - system waits for relock after changing select; the code switches to the new slot with no relock wait
// RL5 - each enable pin gates its own output
// RL6 - enable pins touch only the output gate
// RL7 - differential pair obeys only output one enable
// RL8 - disabled output idles high impedance or low
// RL9 - power down low holds reset, outputs low
// RL10 - power down input pulled down by default
// RL11 - power down high activates the device
// RL12 - blank device drives no usable clocks
// RL13 - any output may carry bypassed reference
// RL14 - spread modulates pll outputs, not bypassed ones
// RL15 - slot holds enable, invert, bypass, drive, spread
// RL16 - select values zero to three map ascending
`timescale 1ns/1ps
`include "clk_cfg_defs.svh"
module clock_output_config_select #(
	parameter int CFG_COUNT = `CFG_COUNT
) (
	input wire sys_clk_in,
	input wire resetn_in,
	input wire [1:0] cfg_sel_in,
	input wire [2:0] out_enable_pin_in,
	input wire power_down_n_in,
	input wire ref_clk_in,
	input wire [2:0] pll_clk_in,
	input wire [2:0] hiz_idle_in,
	input wire prog_we_in,
	input wire [1:0] prog_slot_in,
	input wire [`CFG_WIDTH-1:0] prog_data_in,
	output logic [2:0] clk_out,
	output logic [2:0] clk_oe_n_out,
	output logic [2:0] spread_apply_out,
	output logic [`SS_DEV_WIDTH-1:0] ss_dev_out,
	output logic [`SS_RATE_WIDTH-1:0] ss_rate_out,
	output logic [2*`DRIVE_WIDTH+`DRIVE_WIDTH-1:0] drive_out,
	output logic pll_run_out,
	output logic diff_mode_out
);
	// pin synchronisers
	logic [1:0] sel_m_q, sel_s_q;
	logic [2:0] oe_m_q, oe_s_q;
	logic pd_m_q, pd_s_q;
	logic [2:0] ref_m_q, ref_s_q;
	logic ref_m1_q, ref_s1_q;
	clk_cfg_pkg::cfg_word_type slot_q [CFG_COUNT];
	logic [CFG_COUNT-1:0] slot_valid_q;
	clk_cfg_pkg::run_state_type state_q, state_d;
	clk_cfg_pkg::cfg_word_type live;
	logic [2:0] gate_d;
	logic [2:0] src_d;
	out_gate_if gi ();

	// select and enable pins
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sel_m_q <= 2'h0;
			sel_s_q <= 2'h0;
			oe_m_q <= 3'h0;
			oe_s_q <= 3'h0;
		end else begin
			sel_m_q <= cfg_sel_in;
			sel_s_q <= sel_m_q;
			oe_m_q <= out_enable_pin_in;
			oe_s_q <= oe_m_q;
		end
	end

	// power-down pin, seen as low while in reset
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pd_m_q <= 1'b0; // RL10
			pd_s_q <= 1'b0;
		end else begin
			pd_m_q <= power_down_n_in;
			pd_s_q <= pd_m_q;
		end
	end

	// clock sources sampled as levels
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ref_m_q <= 3'h0;
			ref_s_q <= 3'h0;
			ref_m1_q <= 1'b0;
			ref_s1_q <= 1'b0;
		end else begin
			ref_m_q <= pll_clk_in;
			ref_s_q <= ref_m_q;
			ref_m1_q <= ref_clk_in;
			ref_s1_q <= ref_m1_q;
		end
	end

	// configuration storage, one slot per select value
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			slot_valid_q <= '0; // RL12
		end else if (prog_we_in) begin
			slot_valid_q[prog_slot_in] <= 1'b1; // RL2
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (prog_we_in) begin
			slot_q[prog_slot_in] <= prog_data_in; // RL15
		end
	end

	// select value n addresses slot n, at any time
	assign live = slot_valid_q[sel_s_q] ? slot_q[sel_s_q] : `CFG_RESET; // RL1 RL16

	always_comb begin
		state_d = state_q;
		case (state_q)
			clk_cfg_pkg::st_down: if (pd_s_q) state_d = clk_cfg_pkg::st_blank; // RL11
			clk_cfg_pkg::st_blank: if (slot_valid_q[sel_s_q]) state_d = clk_cfg_pkg::st_run;
			clk_cfg_pkg::st_run: if (!slot_valid_q[sel_s_q]) state_d = clk_cfg_pkg::st_blank;
			default: state_d = clk_cfg_pkg::st_down;
		endcase
		if (!pd_s_q) state_d = clk_cfg_pkg::st_down; // RL9
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= clk_cfg_pkg::st_down;
		end else begin
			state_q <= state_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_ch
			logic en_bit, byp, inv, pin;
			assign en_bit = live[i*`OUT_FIELD_WIDTH+`OUT_EN_POS];
			assign byp = live[i*`OUT_FIELD_WIDTH+`OUT_BYP_POS];
			assign inv = live[i*`OUT_FIELD_WIDTH+`OUT_INV_POS];
			// in differential mode output zero follows output one enable
			assign pin = (i == 0 && live[`CFG_DIFF_POS]) ? oe_s_q[1] : oe_s_q[i]; // RL7 RL5
			assign gate_d[i] = en_bit & pin; // RL3 RL6
			assign src_d[i] = (byp ? ref_s1_q : ref_s_q[i]) ^ inv; // RL13
			assign spread_apply_out[i] = (state_q == clk_cfg_pkg::st_run) & live[`CFG_SS_ON_POS] & ~byp; // RL14
			assign drive_out[i*`DRIVE_WIDTH +: `DRIVE_WIDTH] = live[i*`OUT_FIELD_WIDTH+`OUT_DRV_POS +: `DRIVE_WIDTH];

			chk_out_follows_src: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL3 RL13
				(gi.run && gate_d[i]) |=> (clk_out[i] == $past(src_d[i])))
				else $error("enabled output lost its source");
			chk_off_output_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL5 RL8
				!gate_d[i] |=> !clk_out[i])
				else $error("disabled output not low");
			chk_idle_select: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL8
				(gi.run && !gate_d[i]) |=> (clk_oe_n_out[i] == $past(hiz_idle_in[i])))
				else $error("idle drive select wrong");
			chk_spread_skips_bypass: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL14
				byp |-> !spread_apply_out[i])
				else $error("spread applied to bypassed output");
		end
	endgenerate

	assign gi.run = (state_q == clk_cfg_pkg::st_run);
	assign gi.gate_en = gate_d;
	assign gi.hiz_idle = hiz_idle_in; // RL8
	assign gi.clk_src = src_d;
	assign clk_out = gi.clk_out;
	assign clk_oe_n_out = gi.clk_oe_n;
	assign ss_dev_out = live[`CFG_SS_DEV_POS +: `SS_DEV_WIDTH];
	assign ss_rate_out = live[`CFG_SS_RATE_POS +: `SS_RATE_WIDTH];
	assign pll_run_out = (state_q == clk_cfg_pkg::st_run); // RL6
	assign diff_mode_out = live[`CFG_DIFF_POS];

	out_gate u_gate (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.g(gi.gate)
	);

	sequence seq_waking;
		state_q == clk_cfg_pkg::st_down && pd_s_q;
	endsequence
	sequence seq_ready;
		state_q == clk_cfg_pkg::st_blank && pd_s_q && slot_valid_q[sel_s_q];
	endsequence
	sequence seq_running;
		state_q == clk_cfg_pkg::st_run;
	endsequence

	chk_down_outputs_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL9
		!pd_s_q |=> ##1 (clk_out == 3'h0)) else $error("outputs not low in power down");
	chk_down_drives_pins: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL9
		!gi.run |=> (clk_oe_n_out == 3'h0)) else $error("pins released in power down");
	chk_down_pll_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL9
		(state_q == clk_cfg_pkg::st_down) |-> (!pll_run_out && spread_apply_out == 3'h0))
		else $error("pll active in power down");
	chk_up_leaves_down: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL11
		seq_waking |=> state_q != clk_cfg_pkg::st_down) else $error("power up ignored");
	chk_ready_runs: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL11
		seq_ready |=> seq_running) else $error("programmed slot did not start");
	chk_power_up_steps: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL11
		seq_waking ##1 seq_ready |=> seq_running) else $error("power up sequence broken");
	chk_blank_no_clock: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL12
		(slot_valid_q == '0) |-> ##2 (clk_out == 3'h0)) else $error("blank device drives clock");
	chk_blank_slot_stops: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL12
		!slot_valid_q[sel_s_q] |=> !pll_run_out) else $error("blank slot keeps pll running");
	chk_gate_and: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL3
		gate_d[2] |-> (live[2*`OUT_FIELD_WIDTH] && oe_s_q[2])) else $error("gate without both enables");
	chk_pin_zero_gates: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL5
		(!live[`CFG_DIFF_POS] && !oe_s_q[0]) |-> !gate_d[0]) else $error("output zero ignores its pin");
	chk_diff_ignores_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL7
		live[`CFG_DIFF_POS] |-> (gate_d[0] == (live[`OUT_EN_POS] & oe_s_q[1]))) else $error("diff gate wrong");
	chk_idle_hiz: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL8
		(gi.run && !gate_d[1] && hiz_idle_in[1]) |=> clk_oe_n_out[1]) else $error("idle level wrong");
	chk_bypass_no_spread: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL14
		live[`OUT_FIELD_WIDTH+`OUT_BYP_POS] |-> !spread_apply_out[1]) else $error("spread on bypass");
	chk_sel_picks_slot: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL1 RL16
		slot_valid_q[sel_s_q] |-> (ss_rate_out == slot_q[sel_s_q][`CFG_SS_RATE_POS +: `SS_RATE_WIDTH]))
		else $error("select does not pick its slot");
	chk_enable_keeps_pll: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RL6
		(pll_run_out && $stable(pd_s_q) && $stable(sel_s_q) && $stable(slot_valid_q)) |=> pll_run_out)
		else $error("pll stopped by enable pin");
endmodule

//--- testbench/pin_host.sv
// system-side model driving the select, enable and power-down pins
`timescale 1ns/1ps
module pin_host (
	input wire sys_clk_in,
	output logic [1:0] cfg_sel_out,
	output logic [2:0] oe_pin_out,
	output logic power_down_n_out
);
	initial begin
		cfg_sel_out = 2'h0;
		oe_pin_out = 3'h0;
		power_down_n_out = 1'b0;
	end
	task automatic set(input logic [1:0] sel, input logic [2:0] oe, input logic pd_n);
		@(negedge sys_clk_in);
		cfg_sel_out = sel;
		oe_pin_out = oe;
		power_down_n_out = pd_n;
		repeat (8) @(negedge sys_clk_in);
	endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the configuration select block
`timescale 1ns/1ps
module testbench;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic ref_clk_in = 1'b1;
	logic [2:0] pll_clk_in = 3'h5;
	logic [2:0] hiz_idle_in = 3'h0;
	logic prog_we_in = 1'b0;
	logic [1:0] prog_slot_in = 2'h0;
	clk_cfg_pkg::cfg_word_type prog_data_in = 26'h0;
	logic [1:0] sel;
	logic [2:0] oe;
	logic pd_n;
	logic [2:0] clk_out, oe_n, spread, exp_clk [4];
	logic [4:0] dev;
	logic [3:0] rate;
	logic [5:0] drive;
	logic run, diff;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	initial forever #4 sys_clk_in = ~sys_clk_in;
	pin_host pin_host_i (.sys_clk_in(sys_clk_in), .cfg_sel_out(sel), .oe_pin_out(oe), .power_down_n_out(pd_n));
	clock_output_config_select clock_output_config_select_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.cfg_sel_in(sel), .out_enable_pin_in(oe), .power_down_n_in(pd_n), .ref_clk_in(ref_clk_in),
		.pll_clk_in(pll_clk_in), .hiz_idle_in(hiz_idle_in), .prog_we_in(prog_we_in), .prog_slot_in(prog_slot_in),
		.prog_data_in(prog_data_in), .clk_out(clk_out), .clk_oe_n_out(oe_n), .spread_apply_out(spread),
		.ss_dev_out(dev), .ss_rate_out(rate), .drive_out(drive), .pll_run_out(run), .diff_mode_out(diff));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic prog(input logic [1:0] slot, input logic [2:0] en, input logic [2:0] inv, input logic [2:0] byp,
		input logic dm, input logic ss, input logic [4:0] d, input logic [3:0] r);
		@(negedge sys_clk_in);
		prog_slot_in = slot;
		prog_data_in = {r, d, ss, dm, slot, byp[2], inv[2], en[2], slot, byp[1], inv[1], en[1],
			slot, byp[0], inv[0], en[0]};
		prog_we_in = 1'b1;
		@(negedge sys_clk_in);
		prog_we_in = 1'b0;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		exp_clk = '{3'h5, 3'h3, 3'h5, 3'h0};
		repeat (16) @(negedge sys_clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		chk("down clk", 16'h0, {13'h0, clk_out});
		chk("down oe_n", 16'h0, {13'h0, oe_n});
		pin_host_i.set(2'h0, 3'h7, 1'b1);
		chk("blank clk", 16'h0, {13'h0, clk_out});
		chk("blank run", 16'h0, {15'h0, run});
		prog(2'h0, 3'h7, 3'h0, 3'h0, 1'b0, 1'b0, 5'h01, 4'h1);
		prog(2'h1, 3'h7, 3'h4, 3'h2, 1'b0, 1'b1, 5'h02, 4'h2);
		prog(2'h2, 3'h7, 3'h0, 3'h0, 1'b1, 1'b0, 5'h03, 4'h3);
		prog(2'h3, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 5'h04, 4'h4);
		for (int s = 3; s >= 0; s--) begin
			pin_host_i.set(2'(s), 3'h7, 1'b1);
			chk("spread fields", {7'h0, 5'(s + 1), 4'(s + 1)}, {7'h0, dev, rate});
			chk("slot clk", {13'h0, exp_clk[s]}, {13'h0, clk_out});
			chk("spread", (s == 1) ? 16'h5 : 16'h0, {13'h0, spread});
			chk("diff", (s == 2) ? 16'h1 : 16'h0, {15'h0, diff});
			chk("run", 16'h1, {15'h0, run});
			chk("drive", {10'h0, {3{2'(s)}}}, {10'h0, drive});
		end
		hiz_idle_in = 3'h2;
		pin_host_i.set(2'h0, 3'h5, 1'b1);
		chk("pin clk", 16'h5, {13'h0, clk_out});
		chk("hiz oe_n", 16'h2, {13'h0, oe_n});
		chk("pll kept", 16'h1, {15'h0, run});
		pin_host_i.set(2'h0, 3'h3, 1'b1);
		chk("low idle clk", 16'h1, {13'h0, clk_out});
		chk("low idle oe_n", 16'h0, {13'h0, oe_n});
		hiz_idle_in = 3'h0;
		pin_host_i.set(2'h2, 3'h6, 1'b1);
		chk("diff pin0 ignored", 16'h5, {13'h0, clk_out});
		pin_host_i.set(2'h2, 3'h5, 1'b1);
		chk("diff pin1 off", 16'h4, {13'h0, clk_out});
		pin_host_i.set(2'h2, 3'h7, 1'b0);
		chk("pd clk", 16'h0, {13'h0, clk_out});
		chk("pd oe_n", 16'h0, {13'h0, oe_n});
		chk("pd run", 16'h0, {15'h0, run});
		end_sim();
	end
endmodule
